/* common/rdspin_pkg.sv */
package rdspin_pkg;

  // ==========================================================
  // Register map and field layout
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] STATUS_OFS = 12'h004;
  localparam int CTRL_W = 10;
  localparam int DSS_POS = 0;
  localparam int PFS_POS = 1;
  localparam int TEST_POS = 4;
  localparam int SFT_POS = 8;
  localparam int PDT_POS = 9;
  localparam logic [2:0] PFS_RST = 3'h3;
  localparam logic [3:0] TEST_RST = 4'h0;

  // ==========================================================
  // Serial bus addresses (values are arbitrary)
  localparam logic [7:0] SER_ADDR_IN = 8'h5a;
  localparam logic [7:0] SER_ADDR_OUT = 8'h5b;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int T_SYNC_PULSE_US = 421;
  localparam int T_READ_HOLD_US = 265;
  localparam logic [15:0] SYNC_PULSE_CYC =
    16'((T_SYNC_PULSE_US * 1000) / CLK_PERIOD_NS);
  localparam logic [15:0] READ_HOLD_CYC =
    16'((T_READ_HOLD_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ==========================================================
  // Error block statistics
  localparam logic [5:0] ERR_SET_LAST = 6'h2f;
  localparam logic [5:0] ERR_LIM_LOW = 6'h14;
  localparam logic [5:0] ERR_LIM_MID = 6'h28;

  typedef struct packed {
    logic presence_detect_tuning;
    logic soft_flag_tuning;
    logic [3:0] test_ctl;
    logic pin_polarity_sel;
    logic pin_func_sel_bit1;
    logic pin_func_sel_bit0;
    logic decode_standard_select;
  } rdspin_ctrl_t;

  localparam rdspin_ctrl_t CTRL_RST = '{
    presence_detect_tuning: 1'b0,
    soft_flag_tuning: 1'b0,
    test_ctl: TEST_RST,
    pin_polarity_sel: PFS_RST[2],
    pin_func_sel_bit1: PFS_RST[1],
    pin_func_sel_bit0: PFS_RST[0],
    decode_standard_select: 1'b0
  };

  // Signals from the demodulator and decoder, same clock
  typedef struct packed {
    logic recovered_bit_clock;
    logic recovered_bit_data;
    logic soft_flag_loose;
    logic soft_flag_strict;
    logic subcarrier_out;
    logic broadcast_ident_tone;
    logic traffic_program_flag;
    logic traffic_announce_flag;
    logic block_start;
    logic block_done;
    logic blk_uncorrectable;
    logic blk_corrected;
    logic blk_had_err;
    logic synced;
    logic presence_loose;
    logic presence_strict;
    logic unread_blocks;
  } rdspin_dec_t;

  // Open-drain pins: index 0..4 status a..e, 5 sync, 6 presence, 7 req
  typedef struct packed {
    logic [7:0] pin_o;
    logic [7:0] pin_oe;
  } rdspin_od_t;

endpackage : rdspin_pkg

/* core/rdspin_core.sv */
`timescale 1ns/10ps
module rdspin_core #(
  parameter logic [15:0] SYNC_PULSE = rdspin_pkg::SYNC_PULSE_CYC,
  parameter logic [15:0] READ_HOLD = rdspin_pkg::READ_HOLD_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic bus_chip_enable,
  input wire logic bus_serial_clock,
  input wire logic bus_data_in,
  input wire logic test_pin_first,
  input wire logic test_pin_second,
  input wire logic osc_running,
  input wire rdspin_pkg::rdspin_dec_t dec,
  output rdspin_pkg::rdspin_od_t od,
  output logic offset_e_enable,
  output logic soft_strict_sel,
  output logic standby
);

  // ==========================================================
  // State
  typedef struct packed {
    rdspin_pkg::rdspin_ctrl_t ctrl;
    logic [9:0] sh;
    logic [4:0] bcnt;
    logic [7:0] addr;
    logic in_ph;
    logic out_ph;
    logic [5:0] s1;
    logic [5:0] s2;
    logic cl_d;
    logic ce_d;
    logic [15:0] do_tmr;
    logic [5:0] err_cnt;
    logic [5:0] blk_cnt;
    logic [1:0] err_lvl;
    logic sync_prev;
    logic [15:0] pls_tmr;
    rdspin_pkg::rdspin_od_t od;
    logic standby;
    logic offe;
    logic soft_sel;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } rdspin_st_t;

  rdspin_st_t st_ff;
  rdspin_st_t nxt_st;
  logic cl_rise;
  logic ce_rise;
  logic ce_fall;
  logic osc_ok;
  logic ser_commit;
  logic apb_wr;
  logic apb_setup;
  logic [1:0] mode;
  logic pol;
  logic cnt_mode;
  logic [4:0] lvl;
  logic a_sync;
  logic a_pres;
  logic [5:0] err_now;

  // Pin level to open-drain enable: drive only to pull low
  function automatic logic od_en(input logic level);
    od_en = ~level;
  endfunction : od_en

  // Flag to level under the chosen polarity
  function automatic logic flag_lvl(input logic flag, input logic inv);
    flag_lvl = inv ? flag : ~flag;
  endfunction : flag_lvl

  // Counter to the four error levels
  function automatic logic [1:0] err_code(input logic [5:0] n);
    if (n == 6'h00) begin
      err_code = 2'h0;
    end else if (n <= rdspin_pkg::ERR_LIM_LOW) begin
      err_code = 2'h1;
    end else if (n <= rdspin_pkg::ERR_LIM_MID) begin
      err_code = 2'h2;
    end else begin
      err_code = 2'h3;
    end
  endfunction : err_code

  // ==========================================================
  // Next state
  always_comb begin
    nxt_st = st_ff;
    // Pins: 0 ce, 1 cl, 2 di, 3 test first, 4 test second, 5 osc
    nxt_st.s1 = {osc_running, test_pin_second, test_pin_first,
                 bus_data_in, bus_serial_clock, bus_chip_enable};
    nxt_st.s2 = st_ff.s1;
    nxt_st.cl_d = st_ff.s2[1];
    nxt_st.ce_d = st_ff.s2[0];
    cl_rise = st_ff.s2[1] & ~st_ff.cl_d;
    ce_rise = st_ff.s2[0] & ~st_ff.ce_d;
    ce_fall = ~st_ff.s2[0] & st_ff.ce_d;
    osc_ok = st_ff.s2[5];
    ser_commit = 1'b0;
    apb_setup = psel & ~penable;
    apb_wr = psel & penable & pwrite & st_ff.pready &
             (paddr == rdspin_pkg::CTRL_OFS);

    // Serial control input
    if (!osc_ok) begin
      nxt_st.in_ph = 1'b0;
      nxt_st.out_ph = 1'b0;
      nxt_st.bcnt = 5'h00;
    end else if (ce_rise) begin
      nxt_st.in_ph = (st_ff.addr == rdspin_pkg::SER_ADDR_IN);
      nxt_st.out_ph = (st_ff.addr == rdspin_pkg::SER_ADDR_OUT);
      nxt_st.bcnt = 5'h00;
    end else if (ce_fall) begin
      // Short frames are dropped whole; long frames apply their first ten bits, later bits ignored
      ser_commit = st_ff.in_ph &
                   (st_ff.bcnt == 5'(rdspin_pkg::CTRL_W));
      if (st_ff.out_ph) begin
        nxt_st.do_tmr = READ_HOLD;
      end
      nxt_st.in_ph = 1'b0;
      nxt_st.out_ph = 1'b0;
    end else if (cl_rise && !st_ff.s2[0]) begin
      nxt_st.addr = {st_ff.addr[6:0], st_ff.s2[2]};
    end else if (cl_rise && st_ff.in_ph &&
                 st_ff.bcnt < 5'(rdspin_pkg::CTRL_W)) begin
      nxt_st.sh = {st_ff.s2[2], st_ff.sh[9:1]};
      nxt_st.bcnt = st_ff.bcnt + 5'h01;
    end
    if (ser_commit) begin
      nxt_st.ctrl = rdspin_pkg::rdspin_ctrl_t'(st_ff.sh);
    end else if (apb_wr) begin
      nxt_st.ctrl = rdspin_pkg::rdspin_ctrl_t'(pwdata[9:0]);
    end

    // Read request line
    if (st_ff.do_tmr != 16'h0000) begin
      nxt_st.do_tmr = st_ff.do_tmr - 16'h0001;
      nxt_st.od.pin_oe[7] = 1'b0;
    end else begin
      nxt_st.od.pin_oe[7] = dec.unread_blocks & ~st_ff.out_ph;
    end

    // Error blocks per set
    err_now = st_ff.err_cnt + {5'h00, dec.blk_had_err};
    if (dec.block_done) begin
      if (st_ff.blk_cnt == rdspin_pkg::ERR_SET_LAST) begin
        nxt_st.err_lvl = err_code(err_now);
        nxt_st.err_cnt = 6'h00;
        nxt_st.blk_cnt = 6'h00;
      end else begin
        nxt_st.err_cnt = err_now;
        nxt_st.blk_cnt = st_ff.blk_cnt + 6'h01;
      end
    end

    // Sync state of the block just finished
    if (dec.block_start) begin
      nxt_st.sync_prev = dec.synced;
      nxt_st.pls_tmr = dec.synced ? SYNC_PULSE : 16'h0000;
    end else if (st_ff.pls_tmr != 16'h0000) begin
      nxt_st.pls_tmr = st_ff.pls_tmr - 16'h0001;
    end

    // Output pin routing
    mode = {st_ff.ctrl.pin_func_sel_bit1, st_ff.ctrl.pin_func_sel_bit0};
    pol = st_ff.ctrl.pin_polarity_sel;
    cnt_mode = pol & (mode == 2'h0);
    lvl = 5'h1f;
    unique case (mode)
      2'h1: begin
        lvl[3] = flag_lvl(dec.traffic_program_flag, pol);
        lvl[4] = flag_lvl(dec.traffic_announce_flag, pol);
      end
      2'h2: begin
        lvl[0] = dec.recovered_bit_clock;
        lvl[1] = dec.recovered_bit_data;
        lvl[2] = st_ff.soft_sel ? dec.soft_flag_strict
                                : dec.soft_flag_loose;
        lvl[3] = pol ? ~dec.subcarrier_out : dec.subcarrier_out;
        lvl[4] = flag_lvl(dec.broadcast_ident_tone, pol);
      end
      2'h3: begin
        lvl[0] = dec.recovered_bit_clock;
        lvl[1] = dec.recovered_bit_data;
        lvl[2] = st_ff.soft_sel ? dec.soft_flag_strict
                                : dec.soft_flag_loose;
        lvl[3] = flag_lvl(dec.blk_uncorrectable, pol);
        lvl[4] = flag_lvl(dec.blk_uncorrectable | dec.blk_corrected,
                          pol);
      end
      2'h0: begin
        if (cnt_mode) begin
          lvl[3] = st_ff.err_lvl[1];
          lvl[4] = st_ff.err_lvl[0];
        end
      end
    endcase
    nxt_st.od.pin_oe[0] = od_en(lvl[0]);
    nxt_st.od.pin_oe[1] = od_en(lvl[1]);
    nxt_st.od.pin_oe[2] = od_en(lvl[2]);
    nxt_st.od.pin_oe[3] = od_en(lvl[3]);
    nxt_st.od.pin_oe[4] = od_en(lvl[4]);
    if (st_ff.ctrl.pin_func_sel_bit0 & st_ff.ctrl.pin_func_sel_bit1) begin
      a_sync = st_ff.sync_prev & (st_ff.pls_tmr == 16'h0000);
    end else begin
      a_sync = st_ff.sync_prev;
    end
    a_pres = st_ff.ctrl.presence_detect_tuning ? dec.presence_strict
                                               : dec.presence_loose;
    nxt_st.od.pin_oe[5] = od_en(flag_lvl(a_sync, pol));
    nxt_st.od.pin_oe[6] = od_en(flag_lvl(a_pres, pol));
    nxt_st.od.pin_o = 8'h00;

    // Misc control outputs
    nxt_st.standby = ~st_ff.s2[3] & st_ff.s2[4];
    nxt_st.offe = st_ff.ctrl.decode_standard_select;
    nxt_st.soft_sel = st_ff.ctrl.soft_flag_tuning;

    // APB slave, one wait-free access phase
    if (psel && penable && st_ff.pready) begin
      nxt_st.pready = 1'b0;
      nxt_st.pslverr = 1'b0;
      nxt_st.prdata = 32'h0000_0000;
    end else if (apb_setup) begin
      nxt_st.pready = 1'b1;
      nxt_st.pslverr = 1'b0;
      nxt_st.prdata = 32'h0000_0000;
      if (paddr == rdspin_pkg::CTRL_OFS) begin
        nxt_st.prdata[9:0] = st_ff.ctrl;
      end else if (paddr == rdspin_pkg::STATUS_OFS) begin
        nxt_st.prdata[7:0] = st_ff.od.pin_oe;
        nxt_st.prdata[9:8] = st_ff.err_lvl;
        nxt_st.prdata[10] = st_ff.sync_prev;
        nxt_st.prdata[11] = a_pres;
        nxt_st.prdata[12] = st_ff.standby;
        nxt_st.prdata[13] = osc_ok;
      end else begin
        nxt_st.pslverr = 1'b1;
      end
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
      st_ff.ctrl <= rdspin_pkg::CTRL_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign prdata = st_ff.prdata;
  assign pready = st_ff.pready;
  assign pslverr = st_ff.pslverr;
  assign od = st_ff.od;
  assign offset_e_enable = st_ff.offe;
  assign soft_strict_sel = st_ff.soft_sel;
  assign standby = st_ff.standby;

  // ==========================================================
  // Checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  mode_open_a: assert property (
    st_ff.ctrl[3:1] == 3'h0 |=> st_ff.od.pin_oe[4:0] == 5'h00)
    else $error("status pins driven in open mode");
  std_sel_a: assert property (
    ##1 offset_e_enable == $past(st_ff.ctrl.decode_standard_select))
    else $error("offset E enable does not follow select");
  uncorr_low_a: assert property (
    st_ff.ctrl[3:1] == 3'h3 && dec.blk_uncorrectable
    |=> st_ff.od.pin_oe[4:3] == 2'h3)
    else $error("uncorrectable block not flagged low");
  err_hold_a: assert property (
    !(dec.block_done && st_ff.blk_cnt == rdspin_pkg::ERR_SET_LAST)
    |=> $stable(st_ff.err_lvl))
    else $error("error level moved inside a set");
  err_none_a: assert property (
    dec.block_done && st_ff.blk_cnt == rdspin_pkg::ERR_SET_LAST &&
    st_ff.err_cnt == 6'h00 && !dec.blk_had_err |=> st_ff.err_lvl == 2'h0)
    else $error("clean set not reported as zero");
  sync_pulse_a: assert property (
    dec.block_start && dec.synced |=> st_ff.pls_tmr == SYNC_PULSE)
    else $error("sync pulse not started");
  req_hold_a: assert property (
    ce_fall && st_ff.out_ph && osc_ok |=> (!st_ff.od.pin_oe[7]) [*2])
    else $error("read request not held high after readout");
  ctrl_commit_a: assert property (
    st_ff.ctrl != nxt_st.ctrl |-> ser_commit || apb_wr)
    else $error("control changed outside a commit");
  osc_gate_a: assert property (
    !osc_ok |=> !st_ff.in_ph && !st_ff.out_ph)
    else $error("serial transfer accepted without oscillator");
  standby_a: assert property (
    ##1 standby == (!$past(st_ff.s2[3]) && $past(st_ff.s2[4])))
    else $error("standby does not follow test pins");

endmodule : rdspin_core

/* dv/rdspin_host_model.sv */
`timescale 1ns/10ps
module rdspin_host_model (
  input wire logic pclk,
  input wire logic osc_running,
  output logic bus_chip_enable,
  output logic bus_serial_clock,
  output logic bus_data_in
);
  // ====================
  // Host end of the serial bus, clock idles low
  int gap = 4;

  initial begin
    bus_chip_enable = 1'b0;
    bus_serial_clock = 1'b0;
    bus_data_in = 1'b0;
  end

  task automatic bit_out(input logic b);
    bus_data_in <= b;
    repeat (gap) @(posedge pclk);
    bus_serial_clock <= 1'b1;
    repeat (gap) @(posedge pclk);
    bus_serial_clock <= 1'b0;
  endtask : bit_out

  // Rude skips the oscillator wait, only for refusal tests
  task automatic xfer(input logic [7:0] a, input logic [15:0] d,
    input int n, input logic rude);
    logic [15:0] x;
    x = d & 16'hff0f;
    if (!rude) wait (osc_running === 1'b1);
    @(posedge pclk);
    for (int i = 7; i >= 0; i--) bit_out(a[i]);
    repeat (gap) @(posedge pclk);
    bus_chip_enable <= 1'b1;
    for (int i = 0; i < n; i++) bit_out(x[i]);
    repeat (gap) @(posedge pclk);
    bus_chip_enable <= 1'b0;
    bus_data_in <= ~bus_data_in;
    repeat (gap) @(posedge pclk);
  endtask : xfer
endmodule : rdspin_host_model

/* dv/radio_data_status_pin_control_tb_top.sv */
`timescale 1ns/10ps
module radio_data_status_pin_control_tb_top;
  localparam int SP = 20;
  localparam int RH = 12;
  localparam logic [11:0] CTRL = rdspin_pkg::CTRL_OFS;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic bus_chip_enable, bus_serial_clock, bus_data_in, osc_running;
  logic test_pin_first, test_pin_second;
  logic offset_e_enable, soft_strict_sel, standby;
  rdspin_pkg::rdspin_dec_t dec;
  rdspin_pkg::rdspin_od_t od;
  logic [9:0] m_ctrl, v;
  logic [1:0] lvl;
  logic sp, fu, fc;
  int cnt, nerr, n_fail, samples_checked, cyc, seed;
  int kt[7] = '{0, 1, 20, 21, 40, 41, 48};

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  rdspin_core #(.SYNC_PULSE(16'(SP)), .READ_HOLD(16'(RH))) i_dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .bus_chip_enable, .bus_serial_clock, .bus_data_in,
    .test_pin_first, .test_pin_second, .osc_running, .dec, .od,
    .offset_e_enable, .soft_strict_sel, .standby
  );
  rdspin_host_model i_host (
    .pclk, .osc_running, .bus_chip_enable, .bus_serial_clock, .bus_data_in
  );

  // ====================
  // Shared tasks
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask : tick

  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    samples_checked++;
    if (s !== x) begin
      n_fail++;
      $display("Error t=%0t seen %h exp %h", $time, s, x);
    end
  endtask : chk

  task automatic done(input string s);
    $display("test %s done", s);
  endtask : done

  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : close_out

  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    tick(1);
  endtask : apb

  // One block; he < 0 random, else error bit he[0], synced when he < 2
  task automatic blk(input int he);
    rdspin_pkg::rdspin_dec_t t;
    t = rdspin_pkg::rdspin_dec_t'(17'($random(seed)));
    if (he >= 0) begin
      t.blk_had_err = he[0];
      t.synced = (he < 2);
    end
    t.block_start = 1'b1;
    t.block_done = 1'b1;
    dec <= t;
    tick(1);
    dec.block_start <= 1'b0;
    dec.block_done <= 1'b0;
    tick(1);
    sp = t.synced;
    fu = t.blk_uncorrectable;
    fc = t.blk_corrected;
    nerr += int'(t.blk_had_err);
    cnt++;
    if (cnt == 48) begin
      lvl = nerr == 0 ? 2'h0 : nerr <= 20 ? 2'h1 : nerr <= 40 ? 2'h2 : 2'h3;
      cnt = 0;
      nerr = 0;
    end
  endtask : blk

  // Checks fall inside the mode 3 sync pulse, so sync shows its idle level
  task automatic pins_chk;
    logic [2:0] m;
    logic p;
    logic s;
    logic [7:0] e;
    m = m_ctrl[3:1];
    p = m[2];
    e = 8'h00;
    s = m_ctrl[8] ? dec.soft_flag_strict : dec.soft_flag_loose;
    if (m[1]) begin
      e[0] = ~dec.recovered_bit_clock;
      e[1] = ~dec.recovered_bit_data;
      e[2] = ~s;
    end
    case (m)
      3'h1, 3'h5: begin
        e[3] = dec.traffic_program_flag ^ p;
        e[4] = dec.traffic_announce_flag ^ p;
      end
      3'h2, 3'h6: begin
        e[3] = ~(dec.subcarrier_out ^ p);
        e[4] = dec.broadcast_ident_tone ^ p;
      end
      3'h3, 3'h7: begin
        e[3] = fu ^ p;
        e[4] = (fu | fc) ^ p;
      end
      3'h4: e[4:3] = ~{lvl[0], lvl[1]};
      default: e[4:3] = 2'h0;
    endcase
    e[5] = (m[1] & m[0]) ? p : sp ^ p;
    e[6] = (m_ctrl[9] ? dec.presence_strict : dec.presence_loose) ^ p;
    e[7] = dec.unread_blocks;
    chk(32'(od.pin_oe), 32'(e));
  endtask : pins_chk

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      close_out();
    end
  end

  // ====================
  // Main sequence
  initial begin
    seed = 7079;
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {test_pin_first, test_pin_second, sp, fu, fc, lvl} = '0;
    dec = '0;
    osc_running = 1'b1;
    {n_fail, samples_checked, cyc, cnt, nerr} = '0;
    m_ctrl = 10'h006;
    tick(2);
    presetn <= 1'b1;
    tick(1);
    apb(1'b0, CTRL, 32'h0);
    chk(rd, 32'h0000_0006);
    chk(32'({offset_e_enable, soft_strict_sel, standby}), 32'h0);
    pins_chk();
    apb(1'b0, 12'h008, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    apb(1'b1, 12'h00c, 32'hffff_ffff);
    apb(1'b0, CTRL, 32'h0);
    chk(rd, 32'h0000_0006);
    done("reset");
    for (int i = 0; i < 64; i++) begin
      m_ctrl = 10'($random(seed)) & 10'h30f;
      m_ctrl[3:1] = 3'(i);
      apb(1'b1, CTRL, 32'(m_ctrl));
      blk(-1);
      tick(3);
      pins_chk();
      chk(32'(offset_e_enable), 32'(m_ctrl[0]));
      chk(32'(soft_strict_sel), 32'(m_ctrl[8]));
      chk(32'(od.pin_o), 32'h0);
      apb(1'b0, CTRL, 32'h0);
      chk(rd, 32'(m_ctrl));
    end
    done("modes");
    m_ctrl = 10'h008;
    apb(1'b1, CTRL, 32'(m_ctrl));
    while (cnt != 0) blk(0);
    foreach (kt[j]) begin
      for (int b = 0; b < 48; b++) blk(int'(b < kt[j]));
      tick(3);
      pins_chk();
    end
    done("error count");
    m_ctrl = 10'h006;
    apb(1'b1, CTRL, 32'(m_ctrl));
    blk(1);
    blk(1);
    tick(2);
    chk(32'(od.pin_oe[5]), 32'h0);
    tick(SP);
    chk(32'(od.pin_oe[5]), 32'h1);
    blk(2);
    tick(SP + 3);
    chk(32'(od.pin_oe[5]), 32'h0);
    done("sync pulse");
    dec.unread_blocks <= 1'b1;
    tick(4);
    chk(32'(od.pin_oe[7]), 32'h1);
    i_host.xfer(rdspin_pkg::SER_ADDR_OUT, 16'h0, 8, 1'b0);
    tick(RH - 6);
    chk(32'(od.pin_oe[7]), 32'h0);
    tick(10);
    chk(32'(od.pin_oe[7]), 32'h1);
    done("read request");
    for (int k = 0; k < 4; k++) begin
      v = 10'($random(seed));
      osc_running <= (k != 3);
      i_host.gap = (k == 0) ? 9 : 4;
      tick(4);
      i_host.xfer(k == 2 ? 8'h3c : rdspin_pkg::SER_ADDR_IN, 16'(v),
        k == 1 ? 9 : 10, k == 3);
      tick(8);
      if (k == 0) m_ctrl = v & 10'h30f;
      osc_running <= 1'b1;
      apb(1'b0, CTRL, 32'h0);
      chk(rd, 32'(m_ctrl));
    end
    done("serial");
    for (int k = 0; k < 4; k++) begin
      {test_pin_first, test_pin_second} <= 2'(k);
      tick(5);
      chk(32'(standby), 32'(k == 1));
      apb(1'b0, rdspin_pkg::STATUS_OFS, 32'h0);
      chk(32'(rd[13:12]), 32'({1'b1, k == 1}));
    end
    done("standby");
    close_out();
  end
endmodule : radio_data_status_pin_control_tb_top
